// [wsc_pkg.sv]
// Shared constants, tables, types and strobe sequencing for the write strobe link
`default_nettype none
package wsc_pkg;
  // Link command codes
  localparam logic [1:0] CMD_NOP = 2'h0;
  localparam logic [1:0] CMD_WR  = 2'h1;
  localparam logic [1:0] CMD_RD  = 2'h2;
  localparam logic [1:0] CMD_MRW = 2'h3;
  // Mode register addresses and field positions
  localparam logic [7:0] MR_ADDR_RPST = 8'h01;
  localparam logic [7:0] MR_ADDR_LAT  = 8'h02;
  localparam logic [7:0] MR_ADDR_WPST = 8'h03;
  localparam logic [7:0] MR_ADDR_TERM = 8'h0b;
  localparam int         RPST_BIT     = 7;
  localparam int         LAT_GRP_BIT  = 6;
  localparam int         WPST_BIT     = 1;
  localparam int         TERM_LSB     = 0;
  // Mode field values after reset, and the termination off code
  localparam logic       LAT_GRP_RST  = 1'b0;
  localparam logic       WPST_RST     = 1'b0;
  localparam logic       RPST_RST     = 1'b0;
  localparam logic [2:0] TERM_RST     = 3'h0;
  localparam logic [2:0] TERM_OFF     = 3'h0;
  // Timing, in system cycles, CK cycles or CK half cycles
  localparam int CK_HALF_SYS     = 2;
  localparam int BURST_HALVES    = 16;
  localparam int TCCD_MIN        = 8;
  localparam int TDQSS_CK        = 1;
  localparam int WPRE_CK         = 2;
  localparam int PRE_HALVES      = 4;
  localparam int POST_SHORT_HALF = 1;
  localparam int POST_LONG_HALF  = 3;
  localparam int POST_CK         = 2;
  localparam int RTW_MIN_CK      = 12;
  localparam int DQSTA_CK        = 2;
  localparam int RD_SYNC_CK      = 1;
  localparam int PIPE_W          = 72;
  localparam int WBUF_D          = 8;
  // Per-band tables, index 0 is the slowest band
  typedef logic [7:0] wsc_tab_t [8];
  localparam wsc_tab_t WL_A  = '{8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10, 8'h12};
  localparam wsc_tab_t WL_B  = '{8'h04, 8'h08, 8'h0c, 8'h12, 8'h16, 8'h1a, 8'h1e, 8'h22};
  localparam wsc_tab_t RL_T  = '{8'h06, 8'h0a, 8'h0e, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
  localparam wsc_tab_t ON_A  = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h06, 8'h06, 8'h08};
  localparam wsc_tab_t ON_B  = '{8'h00, 8'h00, 8'h06, 8'h0c, 8'h0e, 8'h12, 8'h14, 8'h18};
  localparam wsc_tab_t OFF_A = '{8'h0f, 8'h12, 8'h15, 8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24};
  localparam wsc_tab_t OFF_B = '{8'h0f, 8'h14, 8'h19, 8'h20, 8'h25, 8'h2a, 8'h2f, 8'h34};
  // Strobe framing phases
  typedef enum logic [3:0] {
    SP_IDLE  = 4'h1,
    SP_PRE   = 4'h2,
    SP_BURST = 4'h4,
    SP_POST  = 4'h8
  } wsc_phase_t;
  typedef struct packed {
    wsc_phase_t ph;
    logic [4:0] cnt;
  } wsc_strobe_t;

  // Table entry for the selected latency group
  function automatic logic [7:0] wsc_pick(logic grp, logic [2:0] band, wsc_tab_t ta,
                                          wsc_tab_t tb);
    return grp ? tb[band] : ta[band];
  endfunction

  // One half-cycle step of preamble, burst and postamble framing
  function automatic wsc_strobe_t wsc_step(wsc_strobe_t s, logic start, logic pre,
                                           logic post_long);
    wsc_strobe_t n;
    logic [4:0]  post_last;
    post_last = post_long ? 5'(POST_LONG_HALF - 1) : 5'(POST_SHORT_HALF - 1);
    n         = s;
    n.cnt     = s.cnt + 5'h01;
    if (s.ph == SP_BURST && s.cnt != 5'(BURST_HALVES - 1)) begin
      n.ph = SP_BURST;
    end else if (start) begin
      n.ph  = SP_BURST;
      n.cnt = 5'h00;
    end else if (s.ph == SP_BURST) begin
      n.ph  = SP_POST;
      n.cnt = 5'h00;
    end else if (pre) begin
      n.ph = SP_PRE;
    end else if (s.ph == SP_POST && s.cnt < post_last) begin
      n.ph = SP_POST;
    end else begin
      n.ph = SP_IDLE;
    end
    return n;
  endfunction
endpackage
`default_nettype wire

// [wsc_link_if.sv]
// Link between memory controller and memory: clock, command and strobe pins
`default_nettype none
interface wsc_link_if;
  logic       ck;
  logic       cke;
  logic [1:0] cmd;
  logic [15:0] ca;
  // Controller drive of strobe and data
  logic       c_dqs_t;
  logic       c_dqs_c;
  logic       c_dqs_t_oe;
  logic       c_dqs_c_oe;
  logic [7:0] c_dq;
  logic       c_dq_oe;
  // Memory drive of strobe and data
  logic       d_dqs_t;
  logic       d_dqs_c;
  logic       d_dqs_oe;
  logic [7:0] d_dq;
  logic       d_dq_oe;
  // Resolved line levels, undriven lines read low
  logic       dqs_t;
  logic       dqs_c;
  logic [7:0] dq;
  assign dqs_t = c_dqs_t_oe ? c_dqs_t : (d_dqs_oe ? d_dqs_t : 1'b0);
  assign dqs_c = c_dqs_c_oe ? c_dqs_c : (d_dqs_oe ? d_dqs_c : 1'b0);
  assign dq    = c_dq_oe ? c_dq : (d_dq_oe ? d_dq : 8'h00);

  modport ctrl (
    output ck, cke, cmd, ca, c_dqs_t, c_dqs_c, c_dqs_t_oe, c_dqs_c_oe, c_dq, c_dq_oe,
    input  dqs_t, dqs_c, dq
  );
  modport dev (
    input  ck, cke, cmd, ca, dqs_t, dqs_c, dq,
    output d_dqs_t, d_dqs_c, d_dqs_oe, d_dq, d_dq_oe
  );
endinterface
`default_nettype wire

// [wsc_dev.sv]
// Memory end: mode fields, write capture, termination window and read strobe
`default_nettype none
module wsc_dev
  import wsc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       ce_i,
  // Configuration and read data
  input  wire logic [2:0] band_i,
  input  wire logic [7:0] rd_data_i,
  // Write data and status
  output logic [7:0]      wr_data_o,
  output logic            wr_valid_o,
  output logic            odt_on_o,
  output logic            lat_grp_o,
  output logic            wpst_o,
  output logic [2:0]      term_field_o,
  // Link
  wsc_link_if.dev         link
);
  localparam int SYNC_W = 29;

  logic [SYNC_W-1:0] sy1;
  logic [SYNC_W-1:0] sy2;
  logic              ck3;
  logic              t3;
  logic              rise;
  logic              edge_any;
  logic [1:0]        s_cmd;
  logic [15:0]       s_ca;
  logic              rpst_long;
  logic [7:0]        rl;
  logic [7:0]        wl;
  logic [7:0]        odt_cnt;
  logic [PIPE_W-1:0] pipe;
  logic [PIPE_W-1:0] ins;
  wsc_strobe_t       st;
  wsc_strobe_t       ns;
  logic              drv;

  // Two-flop synchronisers for every link input except dqs_c
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      sy1 <= '0;
      sy2 <= '0;
      ck3 <= 1'b0;
      t3  <= 1'b0;
    end else if (ce_i) begin
      sy1 <= {link.ck, link.cke, link.cmd, link.ca, link.dqs_t, link.dq};
      sy2 <= sy1;
      ck3 <= sy2[28];
      t3  <= sy2[8];
    end
  end

  // Clock edges and command fields
  assign rise     = ce_i && sy2[28] && !ck3;
  assign edge_any = ce_i && (sy2[28] != ck3);
  assign s_cmd    = sy2[26:25];
  assign s_ca     = sy2[24:9];
  assign rl       = RL_T[band_i];
  assign wl       = wsc_pick(lat_grp_o, band_i, WL_A, WL_B);

  // Mode register fields
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      lat_grp_o    <= LAT_GRP_RST;
      wpst_o       <= WPST_RST;
      rpst_long    <= RPST_RST;
      term_field_o <= TERM_RST;
    end else if (rise && s_cmd == CMD_MRW) begin
      if (s_ca[15:8] == MR_ADDR_LAT) begin
        lat_grp_o <= s_ca[LAT_GRP_BIT];
      end
      if (s_ca[15:8] == MR_ADDR_WPST) begin
        wpst_o <= s_ca[WPST_BIT];
      end
      if (s_ca[15:8] == MR_ADDR_RPST) begin
        rpst_long <= s_ca[RPST_BIT];
      end
      if (s_ca[15:8] == MR_ADDR_TERM) begin
        term_field_o <= s_ca[TERM_LSB+:3];
      end
    end
  end

  // Termination window; strobe on points lie inside it, off points for bands 2 to 7 fall after it
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      odt_cnt  <= 8'h00;
      odt_on_o <= 1'b0;
    end else if (ce_i) begin
      odt_on_o <= odt_cnt != 8'h00;
      if (rise && s_cmd == CMD_WR && term_field_o != TERM_OFF) begin
        odt_cnt <= wl + 8'(TDQSS_CK + TCCD_MIN + POST_CK);
      end else if (rise && odt_cnt != 8'h00) begin
        odt_cnt <= odt_cnt - 8'h01;
      end
    end
  end

  // Write capture on every strobe edge, either scheme, ignored with CKE low
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wr_valid_o <= 1'b0;
      wr_data_o  <= 8'h00;
    end else if (ce_i) begin
      wr_valid_o <= (sy2[8] != t3) && sy2[27] && !drv;
      if ((sy2[8] != t3) && sy2[27] && !drv) begin
        wr_data_o <= sy2[7:0];
      end
    end
  end

  // Read strobe framing
  assign ins = (rise && s_cmd == CMD_RD) ? (PIPE_W'(1) << (8'h02 * rl - 8'h01)) : '0;
  assign ns  = wsc_step(st, pipe[0], |pipe[PRE_HALVES:1], rpst_long);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st   <= '{ph: SP_IDLE, cnt: 5'h00};
      pipe <= '0;
      drv  <= 1'b0;
      link.d_dqs_t  <= 1'b0;
      link.d_dqs_c  <= 1'b0;
      link.d_dqs_oe <= 1'b0;
      link.d_dq     <= 8'h00;
      link.d_dq_oe  <= 1'b0;
    end else if (edge_any) begin
      st   <= ns;
      pipe <= (pipe >> 1) | ins;
      drv  <= ns.ph != SP_IDLE;
      link.d_dqs_t  <= (ns.ph == SP_BURST) && !ns.cnt[0];
      link.d_dqs_c  <= !((ns.ph == SP_BURST) && !ns.cnt[0]);
      link.d_dqs_oe <= ns.ph != SP_IDLE;
      link.d_dq     <= rd_data_i;
      link.d_dq_oe  <= ns.ph == SP_BURST;
    end else if (ce_i) begin
      pipe <= pipe | ins;
    end
  end
endmodule // wsc_dev
`default_nettype wire

// [wsc_ctrl.sv]
// Controller end: link clock, commands, write bursts and write strobe holding
// Behaviour
// - Strobe holding uses read-based or on/off scheme
// - Command spacing always wins over strobe timing
// - Write command turns held complement into differential
// - After postamble, hold complement high while CKE high
// - With CKE low both strobe lines are free
// - Holding waived during read strobe and turnaround
// - On/off: differential from on point until off
// - Strobe-on deadline per latency set and band
// - Strobe-off delay per latency set and band
// - On/off waived over reads and turnarounds
// - Burst toggling counts toward on/off windows
// - Termination off: waiver from latency formula
// - Termination on: waiver equals turnaround parameter
// - Termination on: windows sit inside termination window; for bands 2 to 7 the off point falls after it
// - Termination applied only for nonzero strength field
// - Preamble before, postamble after every burst, except between seamless bursts
// - Mode writes choose postamble options; preamble length is fixed
// - Seamless same-direction bursts drop postamble and preamble
// - Gapped same-direction bursts merge only partially
// - Latency group bit picks set A or B
// - Postamble bit picks half or one-and-half cycles
`default_nettype none
module wsc_ctrl
  import wsc_pkg::*;
#(
  parameter int TURNAROUND_CK = DQSTA_CK // turnaround, not yet fixed
) (
  // Clock, reset, enable
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         ce_i,
  // Configuration
  input  wire logic         strobe_mode_i,
  input  wire logic [2:0]   band_i,
  input  wire logic         cke_i,
  // Command request
  input  wire logic         cmd_valid_i,
  input  wire logic [1:0]   cmd_kind_i,
  input  wire logic [7:0]   cmd_addr_i,
  input  wire logic [7:0]   cmd_op_i,
  input  wire logic [127:0] wr_burst_i,
  output logic              cmd_ready_o,
  output logic              cmd_taken_o,
  // Read data and status
  output logic [7:0]        rd_data_o,
  output logic              rd_valid_o,
  output logic              strobe_hold_o,
  // Link
  wsc_link_if.ctrl          link
);
  logic              ck_q;
  logic [1:0]        div_cnt;
  logic              tick_half;
  logic              tick_fall;
  logic              cke_q;
  logic [1:0]        cmd_q;
  logic [15:0]       ca_q;
  logic              lat_grp;
  logic              wpst;
  logic [2:0]        term;
  logic [7:0]        wl;
  logic [7:0]        on_dl;
  logic [7:0]        off_dl;
  logic [7:0]        since_cmd;
  logic [7:0]        since_rd;
  logic              gap_ok;
  logic              rtw_ok;
  logic              take;
  logic              take_wr;
  logic              take_rd;
  logic signed [9:0] exc_calc;
  logic [7:0]        exc;
  logic [7:0]        off_cnt;
  logic [7:0]        on_cnt;
  logic [7:0]        on_dec;
  logic [7:0]        waive_cnt;
  logic [7:0]        rd_busy;
  logic              wr_pend;
  logic              waived;
  logic              hold_diff;
  logic [PIPE_W-1:0] pipe;
  logic [PIPE_W-1:0] ins;
  wsc_strobe_t       st;
  wsc_strobe_t       ns;
  logic              burst_end;
  logic [127:0]      wbuf [WBUF_D];
  logic [2:0]        wr_wp;
  logic [2:0]        wr_rp;
  logic [2:0]        nxt_rp;
  logic [8:0]        rs1;
  logic [8:0]        rs2;
  logic              rt3;
  logic              t_q;
  logic              c_q;
  logic              t_oe_q;
  logic              c_oe_q;
  logic [7:0]        dq_q;
  logic              dq_oe_q;

  // Link pins from flops
  assign link.ck         = ck_q;
  assign link.cke        = cke_q;
  assign link.cmd        = cmd_q;
  assign link.ca         = ca_q;
  assign link.c_dqs_t    = t_q;
  assign link.c_dqs_c    = c_q;
  assign link.c_dqs_t_oe = t_oe_q;
  assign link.c_dqs_c_oe = c_oe_q;
  assign link.c_dq       = dq_q;
  assign link.c_dq_oe    = dq_oe_q;
  assign strobe_hold_o   = c_oe_q;

  // Link clock divider; commands launch on the falling half
  assign tick_half = ce_i && (div_cnt == 2'(CK_HALF_SYS - 1));
  assign tick_fall = tick_half && ck_q;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      div_cnt <= 2'h0;
      ck_q    <= 1'b0;
    end else if (ce_i) begin
      if (tick_half) begin
        div_cnt <= 2'h0;
        ck_q    <= ~ck_q;
      end else begin
        div_cnt <= div_cnt + 2'h1;
      end
    end
  end

  // Table lookups for the selected latency group
  assign wl     = wsc_pick(lat_grp, band_i, WL_A, WL_B);
  assign on_dl  = wsc_pick(lat_grp, band_i, ON_A, ON_B);
  assign off_dl = wsc_pick(lat_grp, band_i, OFF_A, OFF_B);

  // Command acceptance under spacing limits
  assign gap_ok  = since_cmd >= 8'(TCCD_MIN);
  // Read window must close before the write preamble, or both ends drive the strobe
  assign rtw_ok  = since_rd >= 8'(RTW_MIN_CK) && rd_busy < wl;
  assign take    = tick_fall && cmd_valid_i && cke_q && gap_ok && cmd_kind_i != CMD_NOP
                   && (rtw_ok || cmd_kind_i != CMD_WR);
  assign take_wr = take && cmd_kind_i == CMD_WR;
  assign take_rd = take && cmd_kind_i == CMD_RD;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      since_cmd   <= 8'hff;
      since_rd    <= 8'hff;
      cmd_ready_o <= 1'b0;
      cmd_taken_o <= 1'b0;
      cmd_q       <= CMD_NOP;
      ca_q        <= 16'h0000;
      cke_q       <= 1'b0;
    end else if (ce_i) begin
      cmd_ready_o <= gap_ok && cke_q;
      cmd_taken_o <= take;
      if (tick_fall) begin
        since_cmd <= take ? 8'h01 : (since_cmd == 8'hff ? since_cmd : since_cmd + 8'h01);
        since_rd  <= take_rd ? 8'h01 : (since_rd == 8'hff ? since_rd : since_rd + 8'h01);
        cmd_q     <= take ? cmd_kind_i : CMD_NOP;
        ca_q      <= {cmd_addr_i, cmd_op_i};
        cke_q     <= cke_i;
      end
    end
  end

  // Own copy of the latency, postamble and termination fields written to the memory
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      lat_grp <= LAT_GRP_RST;
      wpst    <= WPST_RST;
      term    <= TERM_RST;
    end else if (take && cmd_kind_i == CMD_MRW) begin
      if (cmd_addr_i == MR_ADDR_LAT) begin
        lat_grp <= cmd_op_i[LAT_GRP_BIT];
      end
      if (cmd_addr_i == MR_ADDR_WPST) begin
        wpst <= cmd_op_i[WPST_BIT];
      end
      if (cmd_addr_i == MR_ADDR_TERM) begin
        term <= cmd_op_i[TERM_LSB+:3];
      end
    end
  end

  // Waiver length after a read; n is the gap beyond its minimum
  assign exc_calc = 10'(wl) - 10'(on_dl) + 10'(TURNAROUND_CK) - 10'(WPRE_CK)
                    - 10'(since_rd - 8'(RTW_MIN_CK));
  assign exc      = (term != TERM_OFF) ? 8'(TURNAROUND_CK)
                    : (exc_calc > 10'sh000 ? exc_calc[7:0] : 8'h00);
  assign on_dec   = (on_cnt == 8'h00) ? 8'h00 : on_cnt - 8'h01;

  // Strobe windows, counted in CK cycles
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      off_cnt   <= 8'h00;
      on_cnt    <= 8'h00;
      waive_cnt <= 8'h00;
      rd_busy   <= 8'h00;
    end else if (tick_fall) begin
      if (take_wr) begin
        off_cnt   <= off_dl;
        on_cnt    <= (off_cnt != 8'h00 && on_dec < on_dl) ? on_dec : on_dl;
        waive_cnt <= exc;
      end else begin
        off_cnt   <= (off_cnt == 8'h00) ? 8'h00 : off_cnt - 8'h01;
        on_cnt    <= on_dec;
        waive_cnt <= (waive_cnt == 8'h00) ? 8'h00 : waive_cnt - 8'h01;
      end
      if (take_rd) begin
        rd_busy <= RL_T[band_i] + 8'(TCCD_MIN + POST_CK + RD_SYNC_CK);
      end else if (rd_busy != 8'h00) begin
        rd_busy <= rd_busy - 8'h01;
      end
    end
  end

  // Holding is waived over reads, turnarounds and CKE low
  assign waived    = !cke_q || rd_busy != 8'h00 || waive_cnt != 8'h00;
  assign hold_diff = strobe_mode_i ? (off_cnt != 8'h00 && on_cnt == 8'h00)
                     : wr_pend;

  // Write burst framing
  assign ins = take_wr ? (PIPE_W'(1) << (8'h02 * (wl + 8'(TDQSS_CK)) - 8'h01)) : '0;
  assign ns  = wsc_step(st, pipe[0], |pipe[PRE_HALVES:1], wpst);
  assign burst_end = st.ph == SP_BURST && st.cnt == 5'(BURST_HALVES - 1);
  assign nxt_rp    = burst_end ? wr_rp + 3'h1 : wr_rp;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st      <= '{ph: SP_IDLE, cnt: 5'h00};
      pipe    <= '0;
      wr_pend <= 1'b0;
      wr_rp   <= 3'h0;
    end else if (tick_half) begin
      st      <= ns;
      pipe    <= (pipe >> 1) | ins;
      wr_rp   <= nxt_rp;
      wr_pend <= take_wr || ns.ph != SP_IDLE || pipe[PIPE_W-1:1] != '0;
    end
  end

  // Write data store, one burst per entry
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wr_wp <= 3'h0;
    end else if (take_wr) begin
      wr_wp <= wr_wp + 3'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (take_wr) begin
      wbuf[wr_wp] <= wr_burst_i;
    end
  end

  // Strobe and data drive per half cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      t_q     <= 1'b0;
      c_q     <= 1'b0;
      t_oe_q  <= 1'b0;
      c_oe_q  <= 1'b0;
      dq_q    <= 8'h00;
      dq_oe_q <= 1'b0;
    end else if (tick_half) begin
      if (ns.ph != SP_IDLE) begin
        t_q    <= (ns.ph == SP_BURST) && !ns.cnt[0];
        c_q    <= !((ns.ph == SP_BURST) && !ns.cnt[0]);
        t_oe_q <= 1'b1;
        c_oe_q <= 1'b1;
      end else if (!waived && hold_diff) begin
        t_q    <= 1'b0;
        c_q    <= 1'b1;
        t_oe_q <= 1'b1;
        c_oe_q <= 1'b1;
      end else if (!waived && !strobe_mode_i) begin
        t_q    <= 1'b0;
        c_q    <= 1'b1;
        t_oe_q <= 1'b0;
        c_oe_q <= 1'b1;
      end else begin
        t_q    <= 1'b0;
        c_q    <= 1'b0;
        t_oe_q <= 1'b0;
        c_oe_q <= 1'b0;
      end
      dq_q    <= wbuf[nxt_rp][{ns.cnt[3:0], 3'h0}+:8];
      dq_oe_q <= ns.ph == SP_BURST;
    end
  end

  // Read data capture on memory strobe edges, synchronised first
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rs1        <= 9'h000;
      rs2        <= 9'h000;
      rt3        <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o  <= 8'h00;
    end else if (ce_i) begin
      rs1        <= {link.dqs_t, link.dq};
      rs2        <= rs1;
      rt3        <= rs2[8];
      rd_valid_o <= rd_busy != 8'h00 && !t_oe_q && rs2[8] != rt3;
      if (rd_busy != 8'h00 && !t_oe_q && rs2[8] != rt3) begin
        rd_data_o <= rs2[7:0];
      end
    end
  end
endmodule // wsc_ctrl
`default_nettype wire

// [wsc_checker.sv]
// Link checks between controller end and memory end
`default_nettype none
module wsc_checker
  import wsc_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk_i,
  input wire logic       rst_b_i,
  // Link signals
  input wire logic       ck,
  input wire logic [1:0] cmd,
  input wire logic       c_dqs_t,
  input wire logic       c_dqs_c,
  input wire logic       c_dqs_t_oe,
  input wire logic       c_dqs_c_oe,
  input wire logic       c_dq_oe,
  input wire logic       d_dqs_oe
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [1:0] cmd_q;
  logic [7:0] since_rd;
  // Previous command and cycles since a read began
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cmd_q    <= CMD_NOP;
      since_rd <= 8'hff;
    end else begin
      cmd_q <= cmd;
      if (cmd == CMD_RD && cmd_q != CMD_RD) since_rd <= 8'h00;
      else if (since_rd != 8'hff) since_rd <= since_rd + 8'h01;
    end
  end
  sequence s_cmd_start;
    $changed(cmd) && cmd != CMD_NOP;
  endsequence
  sequence s_wr_start;
    cmd == CMD_WR && cmd_q != CMD_WR;
  endsequence
  a_cmd_held: assert property (s_cmd_start |=> $stable(cmd) [*3])
    else $error("command left the link early");
  a_rtw_gap: assert property (s_wr_start |-> since_rd >= 8'h2f)
    else $error("write too close to read");
  a_ck_high: assert property ($rose(ck) |=> ck)
    else $error("link clock high too short");
  a_strobe_diff: assert property (c_dqs_t_oe && c_dqs_c_oe |-> c_dqs_t != c_dqs_c)
    else $error("strobe pair not differential");
  a_hold_high: assert property (c_dqs_c_oe && !c_dqs_t_oe |-> c_dqs_c)
    else $error("held complement not high");
  a_no_clash: assert property (c_dqs_t_oe || c_dqs_c_oe |-> !d_dqs_oe)
    else $error("both ends drive the strobe");
  a_dq_strobe: assert property (c_dq_oe |-> c_dqs_t_oe && c_dqs_c_oe)
    else $error("data driven without strobe");
  a_pre_first: assert property ($rose(c_dq_oe) |-> $past(c_dqs_t_oe, 4))
    else $error("write data without preamble");
endmodule // wsc_checker
`default_nettype wire

// [write_strobe_control_tb.sv]
// Bench joining controller end and memory end
`default_nettype none
module write_strobe_control_tb
  import wsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 0, rst_b_i = 0, strobe_mode_i = 0, cke_i = 1, cmd_valid_i = 0;
  logic [2:0] band_i = 3'h0;
  logic [1:0] cmd_kind_i = 2'h0;
  logic [7:0] cmd_addr_i = 8'h00, cmd_op_i = 8'h00, rd_data_i = 8'ha5;
  logic [127:0] wr_burst_i = '0;
  logic cmd_ready_o, cmd_taken_o, rd_valid_o, strobe_hold_o, wr_valid_o, odt_on_o;
  logic lat_grp_o, wpst_o, odt_hit = 0;
  logic [7:0] rd_data_o, wr_data_o;
  logic [2:0] term_field_o;
  int errors = 0, checked = 0, cycles = 0;
  logic [7:0] exp_q[$];
  always #2 sys_clk_i = ~sys_clk_i;
  wsc_link_if lnk ();
  wsc_ctrl i_wsc_ctrl (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
    .strobe_mode_i(strobe_mode_i), .band_i(band_i), .cke_i(cke_i),
    .cmd_valid_i(cmd_valid_i), .cmd_kind_i(cmd_kind_i), .cmd_addr_i(cmd_addr_i),
    .cmd_op_i(cmd_op_i), .wr_burst_i(wr_burst_i), .cmd_ready_o(cmd_ready_o),
    .cmd_taken_o(cmd_taken_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .strobe_hold_o(strobe_hold_o), .link(lnk));
  wsc_dev i_wsc_dev (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
    .band_i(band_i), .rd_data_i(rd_data_i), .wr_data_o(wr_data_o),
    .wr_valid_o(wr_valid_o), .odt_on_o(odt_on_o), .lat_grp_o(lat_grp_o),
    .wpst_o(wpst_o), .term_field_o(term_field_o), .link(lnk));
  wsc_checker i_wsc_checker (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ck(lnk.ck),
    .cmd(lnk.cmd), .c_dqs_t(lnk.c_dqs_t), .c_dqs_c(lnk.c_dqs_c),
    .c_dqs_t_oe(lnk.c_dqs_t_oe), .c_dqs_c_oe(lnk.c_dqs_c_oe),
    .c_dq_oe(lnk.c_dq_oe), .d_dqs_oe(lnk.d_dqs_oe));
  task automatic check(input string what, input logic [127:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Cycle ceiling and sticky termination flag
  always @(posedge sys_clk_i) begin
    cycles++;
    if (odt_on_o === 1'b1) odt_hit <= 1'b1;
    if (cycles == 30000) begin
      errors++;
      complete_run();
    end
  end
  // Hold one request until the controller takes it
  task automatic send(input logic [1:0] k, input logic [7:0] a, o, input logic [127:0] b);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_kind_i <= k;
    cmd_addr_i <= a;
    cmd_op_i <= o;
    wr_burst_i <= b;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (cmd_taken_o !== 1'b1 && n < 900);
    check("taken", 128'(n < 900), 128'(1));
    cmd_valid_i <= 1'b0;
  endtask
  // Compare each beat pulse against the expected queue
  task automatic gather(input int want, span, input logic use_rd);
    int got;
    got = 0;
    repeat (span) begin
      @(posedge sys_clk_i);
      if ((use_rd ? rd_valid_o : wr_valid_o) === 1'b1) begin
        check("beat", use_rd ? rd_data_o : wr_data_o, exp_q.pop_front());
        got++;
      end
    end
    check("beats", 128'(got), 128'(want));
  endtask
  task automatic t_modes();
    int n;
    send(CMD_MRW, MR_ADDR_LAT, 8'h40, '0);
    send(CMD_MRW, MR_ADDR_WPST, 8'h02, '0);
    send(CMD_MRW, MR_ADDR_TERM, 8'h03, '0);
    send(CMD_MRW, MR_ADDR_RPST, 8'h80, '0);
    for (n = 0; n < 64 && term_field_o !== 3'h3; n++) @(posedge sys_clk_i);
    check("group", lat_grp_o, 1'b1);
    check("post", wpst_o, 1'b1);
    check("term", term_field_o, 3'h3);
  endtask
  task automatic t_writes(input int gap);
    logic [127:0] b[2];
    for (int k = 0; k < 32; k++) begin
      b[k / 16][8 * (k % 16) +: 8] = 8'(k * 7 + 1);
      exp_q.push_back(8'(k * 7 + 1));
    end
    fork
      begin
        send(CMD_WR, 8'h00, 8'h00, b[0]);
        repeat (gap) @(posedge sys_clk_i);
        send(CMD_WR, 8'h00, 8'h00, b[1]);
      end
      gather(32, 700, 1'b0);
    join
    check("odt", odt_hit, 1'b1);
  endtask
  task automatic t_read();
    repeat (16) exp_q.push_back(8'ha5);
    fork
      send(CMD_RD, 8'h00, 8'h00, '0);
      gather(16, 500, 1'b1);
    join
  endtask
  task automatic t_rtw();
    int t0;
    send(CMD_RD, 8'h00, 8'h00, '0);
    t0 = cycles;
    send(CMD_WR, 8'h00, 8'h00, '1);
    check("rtw", 128'(cycles - t0 >= 2 * CK_HALF_SYS * RTW_MIN_CK), 128'(1));
  endtask
  task automatic t_hold();
    repeat (200) @(posedge sys_clk_i);
    check("hold", strobe_hold_o, 1'b1);
    check("dqs_c", lnk.dqs_c, 1'b1);
    check("ready", cmd_ready_o, 1'b1);
    cke_i <= 1'b0;
    repeat (40) @(posedge sys_clk_i);
    check("hold_cke", strobe_hold_o, 1'b0);
    check("ready_cke", cmd_ready_o, 1'b0);
    cke_i <= 1'b1;
    band_i <= 3'h7;
    strobe_mode_i <= 1'b1;
    repeat (100) @(posedge sys_clk_i);
    send(CMD_WR, 8'h00, 8'h00, '0);
    repeat (40) @(posedge sys_clk_i);
    check("hold_early", strobe_hold_o, 1'b0);
    repeat (70) @(posedge sys_clk_i);
    check("hold_on", strobe_hold_o, 1'b1);
    repeat (130) @(posedge sys_clk_i);
    check("hold_off", strobe_hold_o, 1'b0);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    t_modes();
    t_writes(0);
    t_writes(64);
    t_read();
    t_rtw();
    t_hold();
    complete_run();
  end
endmodule // write_strobe_control_tb
`default_nettype wire
